// file: core/axis_contact.sv
// Contact detection and stop latch for one gripper axis
`timescale 1ns/10ps
module axis_contact
    import gripper_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Axis signals
    axis_if.axis     ax
);

    logic [7:0] target_q;
    logic [7:0] force_q;
    logic       closing;
    logic       reversed;
    logic       rearm;

    // Direction of travel and re-arm conditions after a contact stop
    assign closing  = ax.target > ax.actual;
    assign reversed = (ax.target != target_q) &&
                      ((ax.state == AX_STOP_CLOSE && ax.target < ax.actual) ||
                       (ax.state == AX_STOP_OPEN  && ax.target > ax.actual));
    assign rearm    = ax.goto_rise || (ax.force_req > force_q) || reversed;

    // Last request seen, for change detection
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            target_q <= 8'h00;
            force_q  <= 8'h00;
        end else begin
            target_q <= ax.target;
            force_q  <= ax.force_req;
        end
    end

    // Contact state of the axis
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ax.state <= AX_MOVING;
        end else if (ax.goto_on) begin
            if (rearm) begin
                ax.state <= AX_MOVING;
            end else if (ax.state == AX_MOVING) begin
                if (ax.contact) begin
                    ax.state <= closing ? AX_STOP_CLOSE : AX_STOP_OPEN;
                end else if (ax.actual == ax.target || ax.limit) begin
                    ax.state <= AX_AT_TARGET;
                end
            end else if (ax.state == AX_AT_TARGET && ax.target != target_q) begin
                ax.state <= AX_MOVING;
            end
        end
    end

    // Motor stop: held while stopped by contact or when go-to is off
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ax.stop <= 1'b1;
        end else begin
            ax.stop <= !ax.goto_on ||
                       (!rearm && (ax.state == AX_STOP_OPEN || ax.state == AX_STOP_CLOSE));
        end
    end

endmodule // axis_contact

// file: core/axis_if.sv
// Signals between the status bank and one axis contact tracker
`timescale 1ns/10ps
interface axis_if;
    import gripper_pkg::*;
    logic [7:0]     target;
    logic [7:0]     actual;
    logic [7:0]     force_req;
    logic           contact;
    logic           limit;
    logic           goto_on;
    logic           goto_rise;
    contact_state_t state;
    logic           stop;

    modport axis (input target, actual, force_req, contact, limit, goto_on, goto_rise,
                  output state, stop);
    modport bank (output target, actual, force_req, contact, limit, goto_on, goto_rise,
                  input state, stop);
endinterface

// file: core/gripper_params.svh
// Register offsets, field positions, fault codes and timing counts of the gripper status bank
`ifndef GRIPPER_PARAMS_SVH
`define GRIPPER_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_GRIPPER_STATE          4'h0
`define OFS_CONTACT_DETECTION      4'h1
`define OFS_FAULT_CODE             4'h2
`define OFS_TARGET_ECHO_A          4'h3
`define OFS_ACTUAL_POS_A           4'h4
`define OFS_MOTOR_CURRENT_A        4'h5
`define OFS_TARGET_ECHO_B          4'h6
`define OFS_ACTUAL_POS_B           4'h7
`define OFS_MOTOR_CURRENT_B        4'h8
`define OFS_TARGET_ECHO_C          4'h9
`define OFS_ACTUAL_POS_C           4'ha
`define OFS_MOTOR_CURRENT_C        4'hb
`define OFS_TARGET_ECHO_SCISSOR    4'hc
`define OFS_ACTUAL_POS_SCISSOR     4'hd
`define OFS_MOTOR_CURRENT_SCISSOR  4'he

// ****************************************
// Field positions and reset values
// ****************************************
`define POS_ACTIVATION_ECHO        0
`define POS_GRASP_MODE_ECHO        1
`define POS_GOTO_ECHO              3
`define POS_SEQUENCING_STATE       4
`define POS_MOTION_STATE           6
`define RST_BYTE                   8'h00

// ****************************************
// Fault codes
// ****************************************
`define FLT_NONE                   4'h0
`define FLT_WAIT_ACTIVATION        4'h5
`define FLT_WAIT_MODE              4'h6
`define FLT_NOT_ACTIVATED          4'h7
`define FLT_COMM_NOT_READY         4'h9
`define FLT_SCISSOR_INTERFERE      4'ha
`define FLT_RELEASE_BUSY           4'hb
`define FLT_ACTIVATION             4'hd
`define FLT_SCISSOR_INTERFERE_LONG 4'he
`define FLT_RELEASE_DONE           4'hf

// ****************************************
// Timing
// ****************************************
`define CLK_HZ                     25000000
`define INTERFERE_LIMIT_SEC        20
`define INTERFERE_CYCLES           (`INTERFERE_LIMIT_SEC * `CLK_HZ)

`endif

// file: core/gripper_pkg.sv
// Types shared by the gripper status bank modules
package gripper_pkg;

    // Per-axis contact report, values are the reported codes
    typedef enum logic [1:0] {
        AX_MOVING     = 2'h0,
        AX_STOP_OPEN  = 2'h1,
        AX_STOP_CLOSE = 2'h2,
        AX_AT_TARGET  = 2'h3
    } contact_state_t;

    // Sequencer, Gray along reset -> activating -> ready -> mode change
    typedef enum logic [1:0] {
        SEQ_RESET      = 2'b00,
        SEQ_ACTIVATING = 2'b01,
        SEQ_READY      = 2'b11,
        SEQ_MODE       = 2'b10
    } seq_state_t;

endpackage

// file: core/gripper_status_register_bank.sv
// Read-only status register bank of a three-finger gripper with sequencing and fault logic
`timescale 1ns/10ps
`include "gripper_params.svh"

//
// Contract
// - Activation echo bit shows the activation request: 0 reset, 1 activated.
// - Two-bit mode echo shows requested grasp mode: basic, pinch, wide, scissor.
// - Go-to echo is 1 moving to target; 0 stopped or busy sequencing.
// - Sequencing field: 0 reset/release, 1 activating, 2 mode change, 3 complete.
// - Motion field: 0 moving, 1 some fingers stopped early, 2 all, 3 reached.
// - Finger A contact: 0 moving, 1 contact opening, 2 contact closing, 3 reached.
// - Fingers B, C and scissor report contact with the same encoding.
// - Contact stops the axis until reverse request, more force, or go-to re-set.
// - Fault code sits in low four bits, upper bits zero; 0 means no fault.
// - Priority faults 5, 6, 7 with indicator off.
// - Minor faults 9, 0xA, 0xB with steady red indicator.
// - Scissor interference is 0xA under 20 s, escalates to 0xE after.
// - Major faults 0xD, 0xE, 0xF blink indicator and need a reset.
// - Major fault clears by activation request 0 then 1, then recalibration runs.
// - Finger A target echo is the A or common position request.
// - Separate target echo bytes for finger B, finger C and scissor.
// - Measured position bytes for A, B, C and scissor.
// - Motor current bytes for the four axes.
// - Finger A request drives A alone only with per-finger option; else all fingers.
// - Axis halted at a software limit reports the target as reached.
module gripper_status_register_bank
    import gripper_pkg::*;
#(
    parameter int unsigned INTERFERE_CYCLES = `INTERFERE_CYCLES
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // Register port
    input  wire logic       i_rd_en,
    input  wire logic [3:0] i_rd_addr,
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_data,
    input  wire logic       i_wr_en,
    input  wire logic [3:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data,
    // Controller requests
    input  wire logic       i_activation_request,
    input  wire logic [1:0] i_grasp_mode_request,
    input  wire logic       i_goto_request,
    input  wire logic       i_per_finger_control_option,
    input  wire logic [7:0] i_target_request_a,
    input  wire logic [7:0] i_target_request_b,
    input  wire logic [7:0] i_target_request_c,
    input  wire logic [7:0] i_target_request_scissor,
    input  wire logic [7:0] i_force_request_a,
    input  wire logic [7:0] i_force_request_b,
    input  wire logic [7:0] i_force_request_c,
    input  wire logic [7:0] i_force_request_scissor,
    // Axis feedback, index 0 A, 1 B, 2 C, 3 scissor
    input  wire logic [7:0] i_actual_pos [4],
    input  wire logic [7:0] i_motor_current [4],
    input  wire logic [3:0] i_contact,
    input  wire logic [3:0] i_soft_limit,
    // Mechanism status
    input  wire logic       i_activation_done,
    input  wire logic       i_activation_error,
    input  wire logic       i_mode_done,
    input  wire logic       i_comm_ready,
    input  wire logic       i_scissor_interference,
    input  wire logic       i_auto_release_busy,
    input  wire logic       i_auto_release_done,
    // Motor control and indicator
    output logic [3:0]      o_axis_stop,
    output logic            o_recalibrate,
    output logic            o_fault_led_on,
    output logic            o_fault_led_blink
);

    // ****************************************
    // Declarations
    // ****************************************
    seq_state_t  seq_q;
    logic        act_req_q;
    logic        goto_req_q;
    logic [1:0]  mode_q;
    logic [1:0]  mode_req_q;
    logic [3:0]  major_q;
    logic [3:0]  fault_d;
    logic [3:0]  fault_q;
    logic [7:0]  tgt_echo_q [4];
    logic [7:0]  pos_q [4];
    logic [7:0]  cur_q [4];
    logic [7:0]  tgt_apply [4];
    logic [7:0]  force_apply [4];
    logic [1:0]  contact [4];
    logic [7:0]  contact_byte;
    logic [1:0]  motion_d;
    logic        goto_eff;
    logic        goto_eff_q;
    logic        act_rise;
    logic        seq_done;
    logic        long_interf;
    logic [7:0]  state_byte;
    logic [$clog2(INTERFERE_CYCLES+1)-1:0] interf_cnt_q;

    localparam int CW = $clog2(INTERFERE_CYCLES + 1);

    axis_if ax [4] ();

    // ****************************************
    // Request capture
    // ****************************************

    // Request levels, sampled once per cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            act_req_q  <= 1'b0;
            goto_req_q <= 1'b0;
            mode_req_q <= 2'h0;
        end else begin
            act_req_q  <= i_activation_request;
            goto_req_q <= i_goto_request;
            mode_req_q <= i_grasp_mode_request;
        end
    end

    assign act_rise = i_activation_request && !act_req_q;

    // ****************************************
    // Activation and mode sequencer
    // ****************************************

    // Activation, recalibration after a reset pulse, and mode changes
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seq_q  <= SEQ_RESET;
            mode_q <= 2'h0;
        end else if (!i_activation_request || i_auto_release_busy || major_q != `FLT_NONE) begin
            seq_q <= SEQ_RESET;
        end else begin
            unique case (seq_q)
                SEQ_RESET: begin
                    if (act_rise) begin
                        seq_q  <= SEQ_ACTIVATING;
                        mode_q <= i_grasp_mode_request;
                    end
                end
                SEQ_ACTIVATING: begin
                    if (i_activation_done) begin
                        seq_q <= SEQ_READY;
                    end
                end
                SEQ_READY: begin
                    if (i_grasp_mode_request != mode_q) begin
                        seq_q  <= SEQ_MODE;
                        mode_q <= i_grasp_mode_request;
                    end
                end
                SEQ_MODE: begin
                    if (i_mode_done) begin
                        seq_q <= SEQ_READY;
                    end
                end
            endcase
        end
    end

    assign seq_done      = (seq_q == SEQ_READY);
    assign o_recalibrate = (seq_q == SEQ_ACTIVATING);

    // ****************************************
    // Scissor interference timer
    // ****************************************

    // Counts how long interference lasts during a mode change
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            interf_cnt_q <= '0;
        end else if (seq_q != SEQ_MODE || !i_scissor_interference) begin
            interf_cnt_q <= '0;
        end else if (!long_interf) begin
            interf_cnt_q <= interf_cnt_q + 1'b1;
        end
    end

    assign long_interf = (interf_cnt_q >= CW'(INTERFERE_CYCLES));

    // ****************************************
    // Fault logic
    // ****************************************

    // Major faults latch until the activation request drops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            major_q <= `FLT_NONE;
        end else if (!i_activation_request) begin
            major_q <= `FLT_NONE;
        end else if (major_q == `FLT_NONE) begin
            if (i_activation_error && seq_q == SEQ_ACTIVATING) begin
                major_q <= `FLT_ACTIVATION;
            end else if (long_interf) begin
                major_q <= `FLT_SCISSOR_INTERFERE_LONG;
            end else if (i_auto_release_done) begin
                major_q <= `FLT_RELEASE_DONE;
            end
        end
    end

    // Highest class wins: major, minor, priority, none
    always_comb begin
        fault_d = `FLT_NONE;
        if (major_q != `FLT_NONE) begin
            fault_d = major_q;
        end else if (!i_comm_ready) begin
            fault_d = `FLT_COMM_NOT_READY;
        end else if (seq_q == SEQ_MODE && i_scissor_interference) begin
            fault_d = `FLT_SCISSOR_INTERFERE;
        end else if (i_auto_release_busy) begin
            fault_d = `FLT_RELEASE_BUSY;
        end else if (i_goto_request && !i_activation_request) begin
            fault_d = `FLT_NOT_ACTIVATED;
        end else if (i_goto_request && seq_q == SEQ_ACTIVATING) begin
            fault_d = `FLT_WAIT_ACTIVATION;
        end else if (i_goto_request && seq_q == SEQ_MODE) begin
            fault_d = `FLT_WAIT_MODE;
        end
    end

    // Fault code and indicator drive
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fault_q           <= `FLT_NONE;
            o_fault_led_on    <= 1'b0;
            o_fault_led_blink <= 1'b0;
        end else begin
            fault_q           <= fault_d;
            o_fault_led_on    <= fault_d >= `FLT_COMM_NOT_READY;
            o_fault_led_blink <= fault_d >= `FLT_ACTIVATION;
        end
    end

    // ****************************************
    // Axis control
    // ****************************************

    // Motion only once sequencing is complete and no release runs
    assign goto_eff = i_goto_request && seq_done && !i_auto_release_busy;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            goto_eff_q <= 1'b0;
        end else begin
            goto_eff_q <= goto_eff;
        end
    end

    // Finger A request steers all fingers unless per-finger control is on
    always_comb begin
        tgt_apply[0]   = i_target_request_a;
        tgt_apply[1]   = i_per_finger_control_option ? i_target_request_b : i_target_request_a;
        tgt_apply[2]   = i_per_finger_control_option ? i_target_request_c : i_target_request_a;
        tgt_apply[3]   = i_target_request_scissor;
        force_apply[0] = i_force_request_a;
        force_apply[1] = i_per_finger_control_option ? i_force_request_b : i_force_request_a;
        force_apply[2] = i_per_finger_control_option ? i_force_request_c : i_force_request_a;
        force_apply[3] = i_force_request_scissor;
    end

    // One contact tracker per axis
    generate
        for (genvar g = 0; g < 4; g++) begin : g_axis
            assign ax[g].target    = tgt_apply[g];
            assign ax[g].actual    = i_actual_pos[g];
            assign ax[g].force_req = force_apply[g];
            assign ax[g].contact   = i_contact[g];
            assign ax[g].limit     = i_soft_limit[g];
            assign ax[g].goto_on   = goto_eff;
            assign ax[g].goto_rise = goto_eff && !goto_eff_q;
            assign contact[g]      = ax[g].state;
            assign o_axis_stop[g]  = ax[g].stop;

            axis_contact u_axis (
                .i_clk   (i_clk),
                .i_rst_b (i_rst_b),
                .ax      (ax[g])
            );
        end
    endgenerate

    // ****************************************
    // Status capture
    // ****************************************

    // Echoes and measured values, refreshed every cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 4; i++) begin
                tgt_echo_q[i] <= `RST_BYTE;
                pos_q[i]      <= `RST_BYTE;
                cur_q[i]      <= `RST_BYTE;
            end
        end else begin
            tgt_echo_q[0] <= i_target_request_a;
            tgt_echo_q[1] <= i_target_request_b;
            tgt_echo_q[2] <= i_target_request_c;
            tgt_echo_q[3] <= i_target_request_scissor;
            for (int i = 0; i < 4; i++) begin
                pos_q[i] <= i_actual_pos[i];
                cur_q[i] <= i_motor_current[i];
            end
        end
    end

    // Overall finger motion summary
    always_comb begin
        if (contact[0] == AX_AT_TARGET && contact[1] == AX_AT_TARGET && contact[2] == AX_AT_TARGET) begin
            motion_d = 2'h3;
        end else if (contact[0] == AX_MOVING || contact[1] == AX_MOVING || contact[2] == AX_MOVING) begin
            motion_d = 2'h0;
        end else if (contact[0] != AX_AT_TARGET && contact[1] != AX_AT_TARGET &&
                     contact[2] != AX_AT_TARGET) begin
            motion_d = 2'h2;
        end else begin
            motion_d = 2'h1;
        end
    end

    // Status byte assembly
    always_comb begin
        state_byte = `RST_BYTE;
        state_byte[`POS_ACTIVATION_ECHO]         = act_req_q;
        state_byte[`POS_GRASP_MODE_ECHO +: 2]    = mode_req_q;
        state_byte[`POS_GOTO_ECHO]               = goto_req_q && goto_eff_q;
        state_byte[`POS_SEQUENCING_STATE +: 2]   = (seq_q == SEQ_READY) ? 2'h3 :
                                                   (seq_q == SEQ_MODE)  ? 2'h2 :
                                                   (seq_q == SEQ_ACTIVATING) ? 2'h1 : 2'h0;
        state_byte[`POS_MOTION_STATE +: 2]       = motion_d;
    end

    assign contact_byte = {contact[3], contact[2], contact[1], contact[0]};

    // ****************************************
    // Register read port
    // ****************************************

    // Registered read data; unmapped offset reads zero, writes dropped
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data  <= `RST_BYTE;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                unique case (i_rd_addr)
                    `OFS_GRIPPER_STATE:         o_rd_data <= state_byte;
                    `OFS_CONTACT_DETECTION:     o_rd_data <= contact_byte;
                    `OFS_FAULT_CODE:            o_rd_data <= {4'h0, fault_q};
                    `OFS_TARGET_ECHO_A:         o_rd_data <= tgt_echo_q[0];
                    `OFS_ACTUAL_POS_A:          o_rd_data <= pos_q[0];
                    `OFS_MOTOR_CURRENT_A:       o_rd_data <= cur_q[0];
                    `OFS_TARGET_ECHO_B:         o_rd_data <= tgt_echo_q[1];
                    `OFS_ACTUAL_POS_B:          o_rd_data <= pos_q[1];
                    `OFS_MOTOR_CURRENT_B:       o_rd_data <= cur_q[1];
                    `OFS_TARGET_ECHO_C:         o_rd_data <= tgt_echo_q[2];
                    `OFS_ACTUAL_POS_C:          o_rd_data <= pos_q[2];
                    `OFS_MOTOR_CURRENT_C:       o_rd_data <= cur_q[2];
                    `OFS_TARGET_ECHO_SCISSOR:   o_rd_data <= tgt_echo_q[3];
                    `OFS_ACTUAL_POS_SCISSOR:    o_rd_data <= pos_q[3];
                    `OFS_MOTOR_CURRENT_SCISSOR: o_rd_data <= cur_q[3];
                    default:                    o_rd_data <= `RST_BYTE;
                endcase
            end
        end
    end

    // Write port has no target: every status byte is read-only
    logic wr_unused;
    assign wr_unused = i_wr_en & (|i_wr_addr) & (|i_wr_data);

endmodule // gripper_status_register_bank

// file: verif/gripper_chk.sv
// Port checks of the gripper status bank
`timescale 1ns/10ps
module gripper_chk (
    // Clock, reset, register port
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_rd_en,
    input wire logic [3:0] i_rd_addr,
    input wire logic o_rd_valid,
    input wire logic [7:0] o_rd_data,
    // Requests and outputs
    input wire logic i_activation_request,
    input wire logic i_goto_request,
    input wire logic [3:0] o_axis_stop,
    input wire logic o_recalibrate,
    input wire logic o_fault_led_on,
    input wire logic o_fault_led_blink
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_read_answer: assert property (i_rd_en |=> o_rd_valid) else $error("no answer");
    a_no_stray: assert property (!i_rd_en |=> !o_rd_valid) else $error("stray valid");
    a_fault_top_zero: assert property (i_rd_en && i_rd_addr == 4'h2 |=> o_rd_data[7:4] == 4'h0) else $error("top");
    a_unmapped_zero: assert property (i_rd_en && i_rd_addr == 4'hf |=> o_rd_data == 8'h00) else $error("hole");
    a_blink_led_on: assert property (o_fault_led_blink |-> o_fault_led_on) else $error("blink");
    a_recal_drop: assert property (!i_activation_request |=> !o_recalibrate) else $error("recal on");
    a_recal_start: assert property ($rose(i_activation_request) |-> ##[1:3] o_recalibrate) else $error("recal");
    a_stop_idle: assert property (!i_goto_request [*4] |-> o_axis_stop == 4'hf) else $error("no stop");
endmodule // gripper_chk

// file: verif/mech_model.sv
// Mechanism model, finishes recalibration after a delay
`timescale 1ns/10ps
module mech_model #(parameter int DLY = 6) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_recal,
    output logic     o_done
);
    int cnt_q;
    // Count cycles of recalibration motion
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) cnt_q <= 0;
        else cnt_q <= i_recal ? cnt_q + 1 : 0;
    end
    assign o_done = i_recal && cnt_q >= DLY;
endmodule // mech_model

// file: verif/test_gripper_status_register_bank.sv
// Self-checking bench of the gripper status bank
`timescale 1ns/10ps
module test_gripper_status_register_bank;
    logic i_clk = 0, i_rst_b = 0, rd_en = 0, wr_en = 0, act = 0, gto = 0, opt = 0, comm = 1, intf = 0, mdone = 0;
    logic aerr = 0, rbusy = 0, rdone = 0;
    logic rvalid, recal, adone, led, blink;
    logic [1:0] md = 0;
    logic [3:0] ra = 0, wa = 0, con = 0, lim = 0, stop;
    logic [7:0] wd = 0, frc = 0, rdata, v, tg [4], ps [4], cu [4];
    int fail_count = 0, check_count = 0;
    always #20 i_clk = ~i_clk;
    gripper_status_register_bank #(.INTERFERE_CYCLES(50)) uut (.i_clk, .i_rst_b, .i_rd_en(rd_en), .i_rd_addr(ra),
        .o_rd_valid(rvalid), .o_rd_data(rdata), .i_wr_en(wr_en), .i_wr_addr(wa), .i_wr_data(wd),
        .i_activation_request(act), .i_grasp_mode_request(md), .i_goto_request(gto), .i_per_finger_control_option(opt),
        .i_target_request_a(tg[0]), .i_target_request_b(tg[1]), .i_target_request_c(tg[2]),
        .i_target_request_scissor(tg[3]), .i_force_request_a(frc), .i_force_request_b(frc), .i_force_request_c(frc),
        .i_force_request_scissor(frc), .i_actual_pos(ps), .i_motor_current(cu), .i_contact(con), .i_soft_limit(lim),
        .i_activation_done(adone), .i_activation_error(aerr), .i_mode_done(mdone), .i_comm_ready(comm),
        .i_scissor_interference(intf), .i_auto_release_busy(rbusy), .i_auto_release_done(rdone),
        .o_axis_stop(stop), .o_recalibrate(recal), .o_fault_led_on(led), .o_fault_led_blink(blink));
    mech_model partner (.i_clk, .i_rst_b, .i_recal(recal), .o_done(adone));
    task automatic complete_run;
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Read a byte until it matches, bounded
    task automatic poll(input int a, input logic [7:0] e, input logic [7:0] m);
        for (int n = 0; n < 200; n++) begin
            @(posedge i_clk);
            rd_en <= 1'b1;
            ra <= 4'(a);
            @(posedge i_clk);
            rd_en <= 1'b0;
            @(negedge i_clk);
            if ((rdata & m) === e) break;
        end
        cmp({7'h0, rvalid}, 8'h01);
        cmp(rdata & m, e);
        if ((rdata & m) !== e) complete_run();
        @(posedge i_clk);
    endtask
    initial begin
        void'($urandom(68587));
        foreach (tg[i]) {tg[i], ps[i], cu[i]} = 24'h0;
        repeat (8) @(posedge i_clk);
        cmp({stop, 1'b0, recal, blink, led}, 8'hf0);
        i_rst_b <= 1'b1;
        gto <= 1'b1;
        poll(2, 8'h07, 8'hff);
        gto <= 1'b0;
        act <= 1'b1;
        poll(0, 8'h11, 8'h31);
        poll(0, 8'h31, 8'h31);
        mdone <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            md <= 2'(m);
            poll(0, {5'h0, 2'(m), 1'b0}, 8'h06);
        end
        mdone <= 1'b0;
        opt <= 1'b1;
        for (int a = 3; a < 16; a++) begin
            v = 8'($urandom);
            if (a % 3 == 0 && a < 15) tg[a / 3 - 1] <= v;
            if (a % 3 == 1) ps[a / 3 - 1] <= v;
            if (a % 3 == 2) cu[a / 3 - 1] <= v;
            frc <= v;
            wr_en <= 1'b1;
            wa <= 4'(a);
            wd <= ~v;
            poll(4'(a), a < 15 ? v : 8'h00, 8'hff);
        end
        wr_en <= 1'b0;
        foreach (tg[i]) {tg[i], ps[i]} <= 16'hc040;
        gto <= 1'b1;
        poll(0, 8'h3f, 8'hff);
        poll(1, 8'h00, 8'hff);
        con <= 4'h1;
        poll(1, 8'h02, 8'hff);
        con <= 4'h0;
        poll(1, 8'h02, 8'hff);
        cmp({4'h0, stop}, 8'h01);
        gto <= 1'b0;
        repeat (20) @(posedge i_clk);
        gto <= 1'b1;
        poll(1, 8'h00, 8'hff);
        lim <= 4'h8;
        poll(1, 8'hc0, 8'hff);
        lim <= 4'h0;
        foreach (ps[i]) ps[i] <= 8'hc0;
        poll(1, 8'hff, 8'hff);
        poll(0, 8'hff, 8'hff);
        opt <= 1'b0;
        tg[0] <= 8'h80;
        poll(1, 8'hc0, 8'hff);
        gto <= 1'b0;
        md <= 2'h0;
        intf <= 1'b1;
        poll(0, 8'h20, 8'h30);
        poll(2, 8'h0a, 8'hff);
        cmp({6'h0, blink, led}, 8'h01);
        poll(2, 8'h0e, 8'hff);
        cmp({6'h0, blink, led}, 8'h03);
        act <= 1'b0;
        intf <= 1'b0;
        poll(0, 8'h00, 8'h31);
        act <= 1'b1;
        poll(0, 8'h31, 8'h31);
        poll(2, 8'h00, 8'hff);
        comm <= 1'b0;
        poll(2, 8'h09, 8'hff);
        comm <= 1'b1;
        rbusy <= 1'b1;
        poll(2, 8'h0b, 8'hff);
        poll(0, 8'h01, 8'h31);
        rbusy <= 1'b0;
        rdone <= 1'b1;
        poll(2, 8'h0f, 8'hff);
        rdone <= 1'b0;
        act <= 1'b0;
        poll(2, 8'h00, 8'hff);
        act <= 1'b1;
        aerr <= 1'b1;
        poll(2, 8'h0d, 8'hff);
        cmp({6'h0, blink, led}, 8'h03);
        complete_run();
    end
endmodule // test_gripper_status_register_bank
bind gripper_status_register_bank gripper_chk chk (.i_clk, .i_rst_b, .i_rd_en, .i_rd_addr, .o_rd_valid, .o_rd_data,
    .i_activation_request, .i_goto_request, .o_axis_stop, .o_recalibrate, .o_fault_led_on, .o_fault_led_blink);
